/* File: frto_consts.svh */
// Offsets, reset values, field positions and timing counts of the fan ramp block
`ifndef FRTO_CONSTS_SVH
`define FRTO_CONSTS_SVH

`define FRTO_CLK_HZ 10000000
`define FRTO_TICK_HZ 10000
`define FRTO_DETECT_MS 5

`define FRTO_ADDR_CFG_SIX 8'h10
`define FRTO_ADDR_REMOTE1_RAMP_CODE_ONE 8'h62
`define FRTO_ADDR_REMOTE1_RAMP_CODE_TWO 8'h63
`define FRTO_ADDR_LIM_R1 8'h6A
`define FRTO_ADDR_LIM_LOC 8'h6B
`define FRTO_ADDR_LIM_R2 8'h6C
`define FRTO_ADDR_HYST_R1L 8'h6D
`define FRTO_ADDR_HYST_R2 8'h6E
`define FRTO_ADDR_CFG_TWO 8'h73

`define FRTO_RST_CFG_SIX 8'h00
`define FRTO_RST_REMOTE1_RAMP_CODE_ONE 8'h00
`define FRTO_RST_REMOTE1_RAMP_CODE_TWO 8'h00
`define FRTO_RST_LIMIT 8'h64
`define FRTO_RST_HYST_R1L 8'h44
`define FRTO_RST_HYST_R2 8'h40
`define FRTO_RST_CFG_TWO 8'h00

`define FRTO_BIT_STRETCH 7
`define FRTO_BIT_KEEP_LO 5
`define FRTO_BIT_DETECT 0
`define FRTO_DUTY_FULL 8'hFF
`define FRTO_DUTY_OFF 8'h00
`define FRTO_STEPS 255

// Full-sweep times in tenths of a second, normal then stretched
`define FRTO_RAMP_DS_0 375
`define FRTO_RAMP_DS_1 188
`define FRTO_RAMP_DS_2 125
`define FRTO_RAMP_DS_3 75
`define FRTO_RAMP_DS_4 47
`define FRTO_RAMP_DS_5 31
`define FRTO_RAMP_DS_6 16
`define FRTO_RAMP_DS_7 8
`define FRTO_SLOW_DS_0 522
`define FRTO_SLOW_DS_1 261
`define FRTO_SLOW_DS_2 174
`define FRTO_SLOW_DS_3 104
`define FRTO_SLOW_DS_4 65
`define FRTO_SLOW_DS_5 44
`define FRTO_SLOW_DS_6 22
`define FRTO_SLOW_DS_7 11

`endif

/* File: frto_pkg.sv */
// Types shared by the fan ramp block
package frto_pkg;
   typedef logic [7:0] frto_byte_t;
   typedef logic [13:0] frto_ticks_t;
   typedef enum logic [1:0] {
      DET_IDLE = 2'b01,
      DET_SINK = 2'b10
   } frto_det_e;
endpackage

/* File: frto_ramp_if.sv */
// Carrier between the control logic and one duty ramp stepper
`timescale 1ns/1ps
interface frto_ramp_if;
   import frto_pkg::*;
   logic tick;
   logic force_full;
   frto_byte_t target;
   frto_ticks_t interval;
   frto_byte_t duty;
   modport ctl (output tick, output force_full, output target, output interval, input duty);
   modport ramp (input tick, input force_full, input target, input interval, output duty);
endinterface

/* File: frto_ramp.sv */
// One output's duty stepper: one code per interval toward the target
`timescale 1ns/1ps
module frto_ramp
   import frto_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   frto_ramp_if.ramp rp
);
`include "frto_consts.svh"

   frto_ticks_t waitCnt_q;
   frto_byte_t duty_q;

   assign rp.duty = duty_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         waitCnt_q <= 14'h0000;
      end else if (rp.force_full || duty_q == rp.target) begin
         waitCnt_q <= 14'h0000;
      end else if (rp.tick) begin
         if (waitCnt_q + 14'h0001 >= rp.interval) begin
            waitCnt_q <= 14'h0000;
         end else begin
            waitCnt_q <= waitCnt_q + 14'h0001;
         end
      end
   end

   // Override jumps at once; leaving it ramps down from full
   always_ff @(posedge mclk) begin
      if (rst) begin
         duty_q <= `FRTO_DUTY_FULL;
      end else if (rp.force_full) begin
         duty_q <= `FRTO_DUTY_FULL;
      end else if (rp.tick && waitCnt_q + 14'h0001 >= rp.interval) begin
         if (duty_q < rp.target) begin
            duty_q <= duty_q + 8'h01;
         end else if (duty_q > rp.target) begin
            duty_q <= duty_q - 8'h01;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_ramp_single_step: assert property (
      !rp.force_full |=> (duty_q == $past(duty_q) || duty_q == $past(duty_q) + 8'h01
         || duty_q == $past(duty_q) - 8'h01))
      else $error("duty moved by more than one code");
   a_ramp_step_spacing: assert property (
      (!rp.force_full && !$past(rp.tick)) |-> duty_q == $past(duty_q) || $past(rp.force_full))
      else $error("duty stepped without a ramp tick");
endmodule

/* File: frto_top.sv */
// Critical-temperature override, start hysteresis, duty ramping and fan presence detect
// Function
// - Any channel above its critical limit forces all three fan outputs to full duty.
// - Full duty holds until that channel falls below limit minus its hysteresis.
// - The override cannot be masked by any automatic fan setting.
// - Three 8-bit critical limits at consecutive addresses, each resetting to 0x64.
// - 4-bit hysteresis fields: remote1 7:4, local 3:0, remote2 next register 7:4.
// - Hysteresis is 1 to 15 degrees; zero disables it and should not be used.
// - One hysteresis per channel serves both fan turn-off and override release.
// - Keep-running bits 7:5 choose off or minimum duty below start minus hysteresis.
// - With keep-running set, hysteresis has no effect below the start temperature.
// - Duty changes gradually at the selected rate until it meets the curve demand.
// - Bits 2:0 of acoustics one set remote1 ramp time, 37.5 s down to 0.8 s.
// - Acoustics two bits 2:0 set local, bits 6:4 set remote2 ramp time.
// - Global stretch bit changes the eight ramp times to 52.2 s down to 1.1 s.
// - Per-channel slow bits in config six slow that channel's ramp four times.
// - Config two bits 3:1 report per output whether a 4-wire fan is sensed.
// - After power-up outputs run at full duty until monitoring is enabled.
`timescale 1ns/1ps
`include "frto_consts.svh"
module frto_top
   import frto_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `FRTO_CLK_HZ / `FRTO_TICK_HZ,
   parameter int unsigned DETECT_CYCLES = `FRTO_DETECT_MS * (`FRTO_CLK_HZ / 1000)
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic [2:0][7:0] tempMeas,
   input wire logic [2:0][7:0] startTemp,
   input wire logic [2:0][7:0] curveDuty,
   input wire logic [2:0][7:0] minDuty,
   input wire logic [2:0][1:0] outChannel,
   input wire logic autoEnable,
   input wire logic [2:0] fanSense,
   output logic [2:0][7:0] fanDuty,
   output logic overrideActive,
   output logic senseSinkEn
);

   frto_byte_t cfgSix_q;
   frto_byte_t acouOne_q;
   frto_byte_t acouTwo_q;
   frto_byte_t hystR1L_q;
   frto_byte_t hystR2_q;
   logic [2:0][7:0] critLimit_q;
   logic [3:0] cfgTwoHigh_q;
   logic [2:0] fanPresent_q;
   logic detectBusy_q;
   frto_byte_t rdData_q;
   logic [2:0] override_q;
   logic overrideAny_q;
   logic [2:0] running_q;
   logic [2:0] senseMeta_q;
   logic [2:0] senseSync_q;
   frto_det_e detState_q;
   logic [22:0] detCnt_q;
   logic detDone;
   logic [15:0] preCnt_q;
   logic tick_q;
   logic [2:0][7:0] target;
   frto_ramp_if rampBus[3] ();

   function automatic logic [3:0] hystOf(input logic [1:0] ch,
                                         input frto_byte_t h1l,
                                         input frto_byte_t h2);
      unique case (ch)
         2'd0: hystOf = h1l[7:4];
         2'd1: hystOf = h1l[3:0];
         default: hystOf = h2[7:4];
      endcase
   endfunction

   function automatic logic [2:0] codeOf(input logic [1:0] ch,
                                         input frto_byte_t a1,
                                         input frto_byte_t a2);
      unique case (ch)
         2'd0: codeOf = a1[2:0];
         2'd1: codeOf = a2[2:0];
         default: codeOf = a2[6:4];
      endcase
   endfunction

   // Ticks of 100 us per duty code; slow bit multiplies by four
   function automatic frto_ticks_t rampTicks(input logic [2:0] code,
                                             input logic stretch,
                                             input logic slow);
      int unsigned ds;
      int unsigned t;
      ds = 0;
      unique case (code)
         3'd0: ds = stretch ? `FRTO_SLOW_DS_0 : `FRTO_RAMP_DS_0;
         3'd1: ds = stretch ? `FRTO_SLOW_DS_1 : `FRTO_RAMP_DS_1;
         3'd2: ds = stretch ? `FRTO_SLOW_DS_2 : `FRTO_RAMP_DS_2;
         3'd3: ds = stretch ? `FRTO_SLOW_DS_3 : `FRTO_RAMP_DS_3;
         3'd4: ds = stretch ? `FRTO_SLOW_DS_4 : `FRTO_RAMP_DS_4;
         3'd5: ds = stretch ? `FRTO_SLOW_DS_5 : `FRTO_RAMP_DS_5;
         3'd6: ds = stretch ? `FRTO_SLOW_DS_6 : `FRTO_RAMP_DS_6;
         3'd7: ds = stretch ? `FRTO_SLOW_DS_7 : `FRTO_RAMP_DS_7;
      endcase
      t = (ds * (`FRTO_TICK_HZ / 10)) / `FRTO_STEPS;
      if (slow) begin
         t = t * 4;
      end
      rampTicks = t[13:0];
   endfunction

   // Register writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfgSix_q <= `FRTO_RST_CFG_SIX;
         acouOne_q <= `FRTO_RST_REMOTE1_RAMP_CODE_ONE;
         acouTwo_q <= `FRTO_RST_REMOTE1_RAMP_CODE_TWO;
         hystR1L_q <= `FRTO_RST_HYST_R1L;
         hystR2_q <= `FRTO_RST_HYST_R2;
         critLimit_q <= {3{`FRTO_RST_LIMIT}};
         cfgTwoHigh_q <= 4'(`FRTO_RST_CFG_TWO >> 4);
      end else if (regWrEn) begin
         unique case (regAddr)
            `FRTO_ADDR_CFG_SIX: cfgSix_q <= regWrData;
            `FRTO_ADDR_REMOTE1_RAMP_CODE_ONE: acouOne_q <= regWrData;
            `FRTO_ADDR_REMOTE1_RAMP_CODE_TWO: acouTwo_q <= regWrData;
            `FRTO_ADDR_LIM_R1: critLimit_q[0] <= regWrData;
            `FRTO_ADDR_LIM_LOC: critLimit_q[1] <= regWrData;
            `FRTO_ADDR_LIM_R2: critLimit_q[2] <= regWrData;
            `FRTO_ADDR_HYST_R1L: hystR1L_q <= regWrData;
            // Low nibble of the remote 2 register has no field
            `FRTO_ADDR_HYST_R2: hystR2_q <= {regWrData[7:4], 4'h0};
            `FRTO_ADDR_CFG_TWO: cfgTwoHigh_q <= regWrData[7:4];
            default: ;
         endcase
      end
   end

   // Read port: data one cycle after the strobe, unmapped reads as zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdData_q <= 8'h00;
      end else if (regRdEn) begin
         unique case (regAddr)
            `FRTO_ADDR_CFG_SIX: rdData_q <= cfgSix_q;
            `FRTO_ADDR_REMOTE1_RAMP_CODE_ONE: rdData_q <= acouOne_q;
            `FRTO_ADDR_REMOTE1_RAMP_CODE_TWO: rdData_q <= acouTwo_q;
            `FRTO_ADDR_LIM_R1: rdData_q <= critLimit_q[0];
            `FRTO_ADDR_LIM_LOC: rdData_q <= critLimit_q[1];
            `FRTO_ADDR_LIM_R2: rdData_q <= critLimit_q[2];
            `FRTO_ADDR_HYST_R1L: rdData_q <= hystR1L_q;
            `FRTO_ADDR_HYST_R2: rdData_q <= hystR2_q;
            `FRTO_ADDR_CFG_TWO: rdData_q <= {cfgTwoHigh_q, fanPresent_q, detectBusy_q};
            default: rdData_q <= 8'h00;
         endcase
      end
   end
   assign regRdData = rdData_q;

   // Critical override per channel; zero hysteresis releases once below the limit
   generate
      for (genvar c = 0; c < 3; c++) begin : g_chan
         logic [3:0] hyst;
         assign hyst = hystOf(2'(c), hystR1L_q, hystR2_q);
         always_ff @(posedge mclk) begin
            if (rst) begin
               override_q[c] <= 1'b0;
            end else if (tempMeas[c] > critLimit_q[c]) begin
               override_q[c] <= 1'b1;
            end else if ({1'b0, tempMeas[c]} + {5'h00, hyst} < {1'b0, critLimit_q[c]}) begin
               override_q[c] <= 1'b0;
            end
         end
         always_ff @(posedge mclk) begin
            if (rst) begin
               running_q[c] <= 1'b0;
            end else if (tempMeas[c] > startTemp[c]) begin
               running_q[c] <= 1'b1;
            end else if ({1'b0, tempMeas[c]} + {5'h00, hyst} < {1'b0, startTemp[c]}) begin
               running_q[c] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         overrideAny_q <= 1'b0;
      end else begin
         overrideAny_q <= |override_q;
      end
   end
   assign overrideActive = overrideAny_q;

   // 100 us enable shared by all ramps
   always_ff @(posedge mclk) begin
      if (rst) begin
         preCnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (preCnt_q >= 16'(TICK_CYCLES - 1)) begin
         preCnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         preCnt_q <= preCnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   generate
      for (genvar o = 0; o < 3; o++) begin : g_out
         logic [1:0] ch;
         logic keepLo;
         // Code 3 selects remote 2, as the hysteresis and rate decoders do
         assign ch = (outChannel[o] == 2'd3) ? 2'd2 : outChannel[o];
         assign keepLo = acouOne_q[`FRTO_BIT_KEEP_LO + o];
         always_comb begin
            if (keepLo) begin
               target[o] = (tempMeas[ch] > startTemp[ch]) ? curveDuty[o] : minDuty[o];
            end else begin
               target[o] = running_q[ch] ? curveDuty[o] : `FRTO_DUTY_OFF;
            end
         end
         assign rampBus[o].tick = tick_q;
         // Power-up full duty until monitoring starts; override ignores all settings
         assign rampBus[o].force_full = overrideAny_q || !autoEnable;
         assign rampBus[o].target = target[o];
         assign rampBus[o].interval = rampTicks(codeOf(ch, acouOne_q, acouTwo_q),
            cfgSix_q[`FRTO_BIT_STRETCH], cfgSix_q[ch]);
         assign fanDuty[o] = rampBus[o].duty;
         frto_ramp frto_ramp_inst (
            .mclk(mclk),
            .rst(rst),
            .rp(rampBus[o])
         );
      end
   endgenerate

   // Presence detect: sink for the detect time, then latch synced sense levels
   always_ff @(posedge mclk) begin
      if (rst) begin
         senseMeta_q <= 3'b000;
         senseSync_q <= 3'b000;
      end else begin
         senseMeta_q <= fanSense;
         senseSync_q <= senseMeta_q;
      end
   end

   assign detDone = (detState_q == DET_SINK) && (detCnt_q >= 23'(DETECT_CYCLES - 1));

   always_ff @(posedge mclk) begin
      if (rst) begin
         detState_q <= DET_IDLE;
         detCnt_q <= 23'h000000;
      end else begin
         unique case (detState_q)
            DET_IDLE: begin
               detCnt_q <= 23'h000000;
               if (regWrEn && regAddr == `FRTO_ADDR_CFG_TWO && regWrData[`FRTO_BIT_DETECT]) begin
                  detState_q <= DET_SINK;
               end
            end
            DET_SINK: begin
               detCnt_q <= detCnt_q + 23'h000001;
               if (detDone) begin
                  detState_q <= DET_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fanPresent_q <= 3'b000;
         detectBusy_q <= 1'b0;
      end else if (detDone) begin
         fanPresent_q <= senseSync_q;
         detectBusy_q <= 1'b0;
      end else if (detState_q == DET_SINK) begin
         detectBusy_q <= 1'b1;
      end
   end
   assign senseSinkEn = detectBusy_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_override_forces_full: assert property (
      (tempMeas[0] > critLimit_q[0] || tempMeas[1] > critLimit_q[1]
      || tempMeas[2] > critLimit_q[2]) |-> ##3 fanDuty == {3{`FRTO_DUTY_FULL}})
      else $error("outputs not full after critical limit crossed");
   a_override_holds_band: assert property (
      override_q[1] && ({1'b0, tempMeas[1]} + {5'h00, g_chan[1].hyst} >= {1'b0, critLimit_q[1]})
      |=> override_q[1])
      else $error("override released inside hysteresis band");
   a_override_unmasked: assert property (
      overrideAny_q [*2] |-> fanDuty == {3{`FRTO_DUTY_FULL}})
      else $error("override masked by fan settings");
   a_limit_reset_value: assert property (
      $fell(rst) |-> critLimit_q == {3{`FRTO_RST_LIMIT}})
      else $error("critical limits not at reset value");
   a_hyst_reset_value: assert property (
      $fell(rst) |-> hystR1L_q == `FRTO_RST_HYST_R1L && hystR2_q == `FRTO_RST_HYST_R2)
      else $error("hysteresis fields not at reset value");
   a_off_below_start: assert property (
      !acouOne_q[`FRTO_BIT_KEEP_LO] && !running_q[g_out[0].ch] |-> target[0] == 8'h00)
      else $error("output not off below start minus hysteresis");
   a_keep_min_duty: assert property (
      acouOne_q[`FRTO_BIT_KEEP_LO + 2] && tempMeas[g_out[2].ch] <= startTemp[g_out[2].ch]
      |-> target[2] == minDuty[2])
      else $error("keep-running output not at minimum duty");
   a_detect_result: assert property (
      detDone |=> fanPresent_q == $past(senseSync_q) && !detectBusy_q)
      else $error("presence result not latched at detect end");
   a_detect_sink_on: assert property (
      $rose(detectBusy_q) |-> ##1 senseSinkEn [*8])
      else $error("sink dropped early during detect");
   a_poweron_full: assert property (
      !autoEnable [*2] |-> fanDuty == {3{`FRTO_DUTY_FULL}})
      else $error("outputs not full while monitoring disabled");
   a_override_release: assert property (
      override_q[1] && !(tempMeas[1] > critLimit_q[1])
      && ({1'b0, tempMeas[1]} + {5'h00, g_chan[1].hyst} < {1'b0, critLimit_q[1]})
      |=> !override_q[1])
      else $error("override kept below limit minus hysteresis");
   a_running_release: assert property (
      running_q[0] && !(tempMeas[0] > startTemp[0])
      && ({1'b0, tempMeas[0]} + {5'h00, g_chan[0].hyst} < {1'b0, startTemp[0]})
      |=> !running_q[0])
      else $error("fan kept on below start minus hysteresis");
   a_override_flag: assert property (
      (|override_q) |=> overrideActive)
      else $error("override flag not raised");
   a_hyst_spare_zero: assert property (
      hystR2_q[3:0] == 4'h0)
      else $error("remote 2 hysteresis low nibble not zero");

   c_override_entry: cover property (!overrideAny_q ##1 overrideAny_q);
   c_override_release: cover property (overrideAny_q ##1 !overrideAny_q);
   c_detect_done: cover property (detDone);
   c_ramp_step: cover property (!rampBus[0].force_full ##1 $changed(fanDuty[0]));
endmodule

/* File: frto_fan_model.sv */
// Model of the fans on the three duty outputs, as seen by the presence sense pins
`timescale 1ns/1ps
module frto_fan_model #(
   parameter logic [2:0] PRESENT = 3'b101
)
(
   input wire logic mclk,
   input wire logic sinkEn,
   output logic [2:0] fanSense
);
   logic [2:0] floatPat;

   initial floatPat = 3'b010;

   // A pin with no fan floats; toggle so a stale level can never pass for a result
   always @(posedge mclk) begin
      floatPat <= ~floatPat;
   end

   // Fan pull-up wins over the sink; an empty pin is pulled low by it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         fanSense[i] = PRESENT[i] ? 1'b1 : (sinkEn ? 1'b0 : floatPat[i]);
      end
   end
endmodule

/* File: frto_top_tb.sv */
// Self-checking bench for the fan ramp and critical override block
`timescale 1ns/1ps
`include "frto_consts.svh"
module frto_top_tb;
   import frto_pkg::*;
   localparam int unsigned TICK = 1;
   localparam int unsigned DET = 20;
   logic mclk, rst, regWrEn, regRdEn, autoEnable, overrideActive, senseSinkEn;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [2:0][7:0] tempMeas, startTemp, curveDuty, minDuty, fanDuty;
   logic [2:0][1:0] outChannel;
   logic [2:0] fanSense;
   logic [7:0] rAddr [10] = '{8'h10, 8'h62, 8'h63, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E,
      8'h73, 8'h20};
   logic [7:0] rExp [10] = '{8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40,
      8'h00, 8'h00};
   int rampDs [16] = '{`FRTO_RAMP_DS_0, `FRTO_RAMP_DS_1, `FRTO_RAMP_DS_2, `FRTO_RAMP_DS_3,
      `FRTO_RAMP_DS_4, `FRTO_RAMP_DS_5, `FRTO_RAMP_DS_6, `FRTO_RAMP_DS_7,
      `FRTO_SLOW_DS_0, `FRTO_SLOW_DS_1, `FRTO_SLOW_DS_2, `FRTO_SLOW_DS_3,
      `FRTO_SLOW_DS_4, `FRTO_SLOW_DS_5, `FRTO_SLOW_DS_6, `FRTO_SLOW_DS_7};
   int badCount = 0;
   int samplesChecked = 0;
   int n;

   frto_top #(.TICK_CYCLES(TICK), .DETECT_CYCLES(DET)) frto_top_inst (
      .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .tempMeas(tempMeas),
      .startTemp(startTemp), .curveDuty(curveDuty), .minDuty(minDuty),
      .outChannel(outChannel), .autoEnable(autoEnable), .fanSense(fanSense),
      .fanDuty(fanDuty), .overrideActive(overrideActive), .senseSinkEn(senseSinkEn));

   frto_fan_model frto_fan_model_inst (.mclk(mclk), .sinkEn(senseSinkEn), .fanSense(fanSense));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic finishTest;
      $display("Checks made %0d, mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic checkByte(input logic [7:0] act, input logic [7:0] exp);
      samplesChecked++;
      if (act !== exp) begin
         badCount++;
         $display("ERROR at %0t: got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic checkCycles(input int act, input int exp);
      samplesChecked++;
      if (act != exp) begin
         badCount++;
         $display("ERROR at %0t: interval %h expected %h", $time, act, exp);
      end
   endtask

   task automatic checkDuties(input logic [2:0][7:0] exp);
      for (int i = 0; i < 3; i++) begin
         checkByte(fanDuty[i], exp[i]);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge mclk);
      regWrEn = 1'b0;
      // Idle cycle so a following write never re-raises the strobe in this step
      @(negedge mclk);
   endtask

   task automatic checkReg(input logic [7:0] a, input logic [7:0] exp);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge mclk);
      regRdEn = 1'b0;
      @(negedge mclk);
      checkByte(regRdData, exp);
   endtask

   // Bounded wait for all three duties to settle on a value
   task automatic waitDuty(input logic [2:0][7:0] exp, input int limit);
      int k;
      k = 0;
      while (fanDuty !== exp && k < limit) begin
         @(negedge mclk);
         k++;
      end
   endtask

   // Cycles until the duty of one output next moves
   task automatic stepTime(input int idx, output int cnt);
      logic [7:0] prev;
      prev = fanDuty[idx];
      cnt = 0;
      while (fanDuty[idx] === prev && cnt < 10000) begin
         @(negedge mclk);
         cnt++;
      end
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      badCount++;
      finishTest();
   end

   initial begin
      rst = 1'b1;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      autoEnable = 1'b0;
      tempMeas = {3{8'h20}};
      startTemp = {3{8'h30}};
      curveDuty = {3{8'h80}};
      minDuty = {3{8'h10}};
      outChannel = {2'h2, 2'h1, 2'h0};
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      checkDuties({3{8'hFF}});
      checkByte({7'h00, overrideActive}, 8'h00);
      for (int i = 0; i < 10; i++) begin
         checkReg(rAddr[i], rExp[i]);
      end
      regWrite(8'h6C, 8'h5A);
      checkReg(8'h6C, 8'h5A);
      regWrite(8'h6C, 8'h64);
      regWrite(8'h6E, 8'hFF);
      checkReg(8'h6E, 8'hF0);
      regWrite(8'h6E, 8'h40);
      checkByte({7'h00, senseSinkEn}, 8'h00);
      // Monitoring still off, so all outputs already run at full duty
      regWrite(8'h73, 8'h01);
      checkByte({7'h00, senseSinkEn}, 8'h01);
      checkReg(8'h73, 8'h01);
      cyc(DET + 5);
      checkByte({7'h00, senseSinkEn}, 8'h00);
      checkReg(8'h73, 8'h0A);
      regWrite(8'h73, 8'h50);
      checkReg(8'h73, 8'h5A);
      regWrite(8'h62, 8'h27);
      regWrite(8'h63, 8'h77);
      autoEnable = 1'b1;
      waitDuty({8'h00, 8'h00, 8'h10}, 9000);
      checkDuties({8'h00, 8'h00, 8'h10});
      tempMeas = {3{8'h31}};
      waitDuty({3{8'h80}}, 5000);
      checkDuties({3{8'h80}});
      // Inside the hysteresis band: only the keep-running output leaves the curve
      tempMeas = {3{8'h2E}};
      waitDuty({8'h80, 8'h80, 8'h10}, 4000);
      checkDuties({8'h80, 8'h80, 8'h10});
      tempMeas = {3{8'h2B}};
      waitDuty({8'h00, 8'h00, 8'h10}, 5000);
      checkDuties({8'h00, 8'h00, 8'h10});
      tempMeas[1] = 8'h65;
      cyc(1);
      checkByte({7'h00, overrideActive}, 8'h00);
      cyc(1);
      checkByte({7'h00, overrideActive}, 8'h01);
      cyc(1);
      checkDuties({3{8'hFF}});
      tempMeas[1] = 8'h60;
      cyc(20);
      checkByte({7'h00, overrideActive}, 8'h01);
      checkDuties({3{8'hFF}});
      tempMeas[1] = 8'h5F;
      cyc(3);
      checkByte({7'h00, overrideActive}, 8'h00);
      regWrite(8'h63, 8'h76);
      regWrite(8'h10, 8'h07);
      stepTime(0, n);
      stepTime(0, n);
      checkCycles(n, 4 * ((`FRTO_RAMP_DS_7 * 1000) / `FRTO_STEPS) * TICK);
      stepTime(1, n);
      stepTime(1, n);
      checkCycles(n, 4 * ((`FRTO_RAMP_DS_6 * 1000) / `FRTO_STEPS) * TICK);
      stepTime(2, n);
      stepTime(2, n);
      checkCycles(n, 4 * ((`FRTO_RAMP_DS_7 * 1000) / `FRTO_STEPS) * TICK);
      for (int s = 0; s < 2; s++) begin
         regWrite(8'h10, s ? 8'h80 : 8'h00);
         for (int c = 0; c < 8; c++) begin
            // All keep bits set, so output three holds minimum duty too; output two stays on its curve above start
            regWrite(8'h62, 8'hE0 | 8'(c));
            stepTime(0, n);
            stepTime(0, n);
            checkCycles(n, ((rampDs[s * 8 + c] * 1000) / `FRTO_STEPS) * TICK);
         end
      end
      finishTest();
   end
endmodule
